// [rtl/csc_scan_control.sv]
// converter scan control: apb registers, scan sequencer, clocks and completion interrupt
// How it works
// - channel field bits 5..1 picks input 0..25, code 26 internal channel
// - trigger bit going 0 to 1 starts exactly one scan
// - scan end clears trigger bit and sets completion flag
// - converter clock codes 0..3 give 8, 6, 4, 3 MHz
// - offset clock codes 0..3 give 12, 8, 4, 2 MHz
// - result bits 11..8 in high register 3..0, bits 7..0 in low
// - wait after sampling lasts three plus wait field converter cycles
// - gap bit inserts one converter cycle between sampling and compare
// - sample delay codes give 0, 2, 4 or 8 converter cycles
// - filter bit turns the front-end rc filter on
// - bias bit 2 comparator, bit 3 op-amp: 0 is 4 uA, 1 is 5 uA
// - offset-cancel mode resets to 10 and passes to the front end
// - sampling always lasts four converter cycles: the sample time field is never written and stays at its reset value 0
`timescale 1ns/10ps
module csc_scan_control
	import csc_pkg::*;
(
	input  wire logic        clk_sys_in,
	input  wire logic        resetn_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic        conv_done_in,
	input  wire logic [11:0] conv_result_in,
	output csc_analog_type   analog_out,
	output logic             converter_clk_out,
	output logic             offset_clk_out,
	output logic             irq_out
);
	logic [7:0]     scan_channel_control;
	logic [7:0]     converter_clock_control;
	logic [7:0]     converter_result_high;
	logic [7:0]     converter_result_low;
	logic [7:0]     sampling_timing_one;
	logic [7:0]     sampling_timing_two;
	logic [7:0]     irq_status;
	logic [7:0]     irq_mask;
	logic [7:0]     sample_time_field;
	csc_state_type  state;
	logic           setup_phase;
	logic           access_phase;
	logic           wr_access;
	logic           rd_access;
	logic [9:0]     reg_index;
	logic           addr_aligned;
	logic           addr_mapped;
	logic [7:0]     read_value;
	logic           start_request;
	logic           scan_done;
	logic           conv_tick;
	logic           timer_load;
	logic [10:0]    timer_value;
	logic           timer_done;
	logic           done_sync_a;
	logic           done_sync_b;
	logic           done_prev;
	logic           done_rise;
	logic [11:0]    result_sync_a;
	logic [11:0]    result_sync_b;
	logic [4:0]     post_sample_wait;
	logic           sample_compare_gap;
	logic [1:0]     sample_delay_select;
	logic [1:0]     converter_clock_divide;
	logic [1:0]     offset_clock_select;

	// apb decode
	assign setup_phase  = psel_in && !penable_in;
	assign access_phase = psel_in && penable_in;
	assign wr_access    = access_phase && pwrite_in && addr_mapped;
	assign rd_access    = access_phase && !pwrite_in && addr_mapped;
	assign reg_index    = paddr_in[11:2];
	assign addr_aligned = (paddr_in[1:0] == 2'b00);
	assign pready_out   = 1'b1;

	// field views
	assign post_sample_wait       = sampling_timing_one[7:3];
	assign sample_compare_gap     = sampling_timing_one[CSC_BIT_GAP];
	assign sample_delay_select    = sampling_timing_one[1:0];
	assign converter_clock_divide = converter_clock_control[1:0];
	assign offset_clock_select    = converter_clock_control[3:2];

	always_comb
	begin
		addr_mapped = 1'b0;
		read_value  = 8'h00;
		if (addr_aligned)
		begin
			addr_mapped = 1'b1;
			case (reg_index)
				CSC_IDX_SCAN:       read_value = scan_channel_control;
				CSC_IDX_CLOCK:      read_value = converter_clock_control;
				CSC_IDX_RES_HIGH:   read_value = converter_result_high;
				CSC_IDX_RES_LOW:    read_value = converter_result_low;
				CSC_IDX_TIMING_ONE: read_value = sampling_timing_one;
				CSC_IDX_TIMING_TWO: read_value = sampling_timing_two;
				CSC_IDX_IRQ_STATUS: read_value = irq_status;
				CSC_IDX_IRQ_MASK:   read_value = irq_mask;
				default:            addr_mapped = 1'b0;
			endcase
		end
	end

	// read data and error are captured in the setup cycle so the access cycle answers at once
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			prdata_out  <= 32'h0000_0000;
			pslverr_out <= 1'b0;
		end
		else if (setup_phase)
		begin
			prdata_out  <= pwrite_in ? 32'h0000_0000 : {24'h00_0000, read_value};
			pslverr_out <= !addr_mapped;
		end
		else if (!psel_in)
			pslverr_out <= 1'b0;
	end

	// trigger: a write that lifts the start bit while idle
	assign start_request = wr_access && (reg_index == CSC_IDX_SCAN)
		&& pwdata_in[CSC_BIT_START] && !scan_channel_control[CSC_BIT_START]
		&& state[0];

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			scan_channel_control <= CSC_RST_SCAN;
		else if (scan_done)
			scan_channel_control[CSC_BIT_START] <= 1'b0;
		else if (wr_access && (reg_index == CSC_IDX_SCAN))
		begin
			// channel is held during a scan; the start bit only rises through a trigger
			if (state[0])
				scan_channel_control <= pwdata_in[7:0] & CSC_MASK_SCAN;
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			converter_clock_control <= CSC_RST_CLOCK;
			sampling_timing_one     <= CSC_RST_TIMING_ONE;
			sampling_timing_two     <= CSC_RST_TIMING_TWO;
			sample_time_field       <= CSC_RST_TIMING_ONE;
			irq_mask                <= CSC_RST_IRQ;
		end
		else if (wr_access)
		begin
			case (reg_index)
				CSC_IDX_CLOCK:      converter_clock_control <= pwdata_in[7:0] & CSC_MASK_CLOCK;
				CSC_IDX_TIMING_ONE: sampling_timing_one     <= pwdata_in[7:0];
				CSC_IDX_TIMING_TWO: sampling_timing_two     <= pwdata_in[7:0] & CSC_MASK_TIMING2;
				CSC_IDX_IRQ_MASK:   irq_mask                <= pwdata_in[7:0] & CSC_MASK_IRQ;
				default:            sample_time_field       <= sample_time_field;
			endcase
		end
	end

	// completion flag: sticky, set wins; a status read clears only the bits it returned
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			irq_status <= CSC_RST_IRQ;
		else if (scan_done)
			irq_status[CSC_BIT_IRQ_DONE] <= 1'b1;
		else if (rd_access && (reg_index == CSC_IDX_IRQ_STATUS))
			irq_status <= irq_status & ~prdata_out[7:0];
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			irq_out <= 1'b0;
		else
			irq_out <= |(irq_status & irq_mask);
	end

	// converter and offset-cancellation clocks
	csc_rate_gen u_conv_rate
	(
		.clk_sys_in (clk_sys_in),
		.resetn_in  (resetn_in),
		.rate_in    (CSC_CONV_RATE[converter_clock_divide]),
		.clk_out    (converter_clk_out),
		.rise_out   (conv_tick)
	);

	csc_rate_gen u_offs_rate
	(
		.clk_sys_in (clk_sys_in),
		.resetn_in  (resetn_in),
		.rate_in    (CSC_OFFS_RATE[offset_clock_select]),
		.clk_out    (offset_clk_out),
		.rise_out   ()
	);

	// converter inputs come from the analog domain
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			done_sync_a   <= 1'b0;
			done_sync_b   <= 1'b0;
			done_prev     <= 1'b0;
			result_sync_a <= 12'h000;
			result_sync_b <= 12'h000;
		end
		else
		begin
			done_sync_a   <= conv_done_in;
			done_sync_b   <= done_sync_a;
			done_prev     <= done_sync_b;
			result_sync_a <= conv_result_in;
			result_sync_b <= result_sync_a;
		end
	end

	assign done_rise = done_sync_b && !done_prev;

	// duration loaded into the timer for the delay, sample, gap and wait steps of the sequence
	always_comb
	begin
		timer_load  = 1'b0;
		timer_value = 11'h000;
		case (state)
			CSC_IDLE:
			begin
				timer_load  = start_request;
				timer_value = CSC_DELAY_CYC[sample_delay_select];
			end
			CSC_DELAY:
			begin
				timer_load  = timer_done;
				timer_value = 11'({3'h0, sampling_timing_two[7] ? 8'h00 : sample_time_field} + 11'h001)
					<< CSC_SAMPLE_SHIFT;
			end
			CSC_SAMPLE:
			begin
				timer_load  = timer_done;
				timer_value = sample_compare_gap ? CSC_GAP_CYC : 11'h000;
			end
			CSC_GAP:
			begin
				timer_load  = timer_done;
				timer_value = CSC_WAIT_BASE + {6'h00, post_sample_wait};
			end
			default:
			begin
				timer_load  = 1'b0;
				timer_value = 11'h000;
			end
		endcase
	end

	csc_cycle_timer u_timer
	(
		.clk_sys_in (clk_sys_in),
		.resetn_in  (resetn_in),
		.load_in    (timer_load),
		.value_in   (timer_value),
		.tick_in    (conv_tick),
		.done_out   (timer_done)
	);

	// scan sequencer
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			state <= CSC_IDLE;
		else
		begin
			case (state)
				CSC_IDLE:    if (start_request) state <= CSC_DELAY;
				CSC_DELAY:   if (timer_done) state <= CSC_SAMPLE;
				CSC_SAMPLE:  if (timer_done) state <= CSC_GAP;
				CSC_GAP:     if (timer_done) state <= CSC_WAIT;
				CSC_WAIT:    if (timer_done) state <= CSC_CONVERT;
				CSC_CONVERT: if (done_rise) state <= CSC_STORE;
				CSC_STORE:   state <= CSC_IDLE;
				default:     state <= CSC_IDLE;
			endcase
		end
	end

	// result lands in the registers one cycle before the flag
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			converter_result_high <= CSC_RST_RESULT;
			converter_result_low  <= CSC_RST_RESULT;
		end
		else if (state[5] && done_rise)
		begin
			converter_result_high <= {4'h0, result_sync_b[11:8]};
			converter_result_low  <= result_sync_b[7:0];
		end
	end

	assign scan_done = state[6];

	// analog front-end controls straight from registers and state
	always_comb
	begin
		analog_out.channel              = scan_channel_control[5:1];
		analog_out.filter_on            = sampling_timing_two[CSC_BIT_FILTER];
		analog_out.vref_select          = sampling_timing_two[5:4];
		analog_out.opamp_bias_high      = sampling_timing_two[3];
		analog_out.comparator_bias_high = sampling_timing_two[2];
		analog_out.offset_cancel_mode   = sampling_timing_two[1:0];
		analog_out.sample               = state[2];
		analog_out.convert              = state[5];
	end

endmodule : csc_scan_control

// [include/csc_pkg.sv]
// package for the converter scan control block: register map, fields, timing tables
package csc_pkg;

	// register indices; byte address is four times the index
	localparam logic [9:0]  CSC_IDX_SCAN       = 10'h0b5;
	localparam logic [9:0]  CSC_IDX_CLOCK      = 10'h0b6;
	localparam logic [9:0]  CSC_IDX_RES_HIGH   = 10'h0b9;
	localparam logic [9:0]  CSC_IDX_RES_LOW    = 10'h0ba;
	localparam logic [9:0]  CSC_IDX_TIMING_ONE = 10'h0bb;
	localparam logic [9:0]  CSC_IDX_TIMING_TWO = 10'h0bc;
	localparam logic [9:0]  CSC_IDX_IRQ_STATUS = 10'h0c8;
	localparam logic [9:0]  CSC_IDX_IRQ_MASK   = 10'h0c9;

	// reset values and writable masks
	localparam logic [7:0]  CSC_RST_SCAN       = 8'h00;
	localparam logic [7:0]  CSC_RST_CLOCK      = 8'h00;
	localparam logic [7:0]  CSC_RST_RESULT     = 8'h00;
	localparam logic [7:0]  CSC_RST_TIMING_ONE = 8'h00;
	localparam logic [7:0]  CSC_RST_TIMING_TWO = 8'h02;
	localparam logic [7:0]  CSC_RST_IRQ        = 8'h00;
	localparam logic [7:0]  CSC_MASK_SCAN      = 8'h3f;
	localparam logic [7:0]  CSC_MASK_CLOCK     = 8'h0f;
	localparam logic [7:0]  CSC_MASK_TIMING2   = 8'h7f;
	localparam logic [7:0]  CSC_MASK_IRQ       = 8'h01;

	// field positions
	localparam int          CSC_BIT_START      = 0;
	localparam int          CSC_BIT_GAP        = 2;
	localparam int          CSC_BIT_FILTER     = 6;
	localparam int          CSC_BIT_IRQ_DONE   = 0;

	// rates in MHz; each generator runs at twice the clock it makes
	localparam logic [8:0]  CSC_SYS_MHZ        = 9'h0fa;
	localparam logic [4:0]  CSC_CONV_RATE [4]  = '{5'h10, 5'h0c, 5'h08, 5'h06};
	localparam logic [4:0]  CSC_OFFS_RATE [4]  = '{5'h18, 5'h10, 5'h08, 5'h04};

	// sequence lengths in converter-clock cycles
	localparam logic [10:0] CSC_DELAY_CYC [4]  = '{11'h000, 11'h002, 11'h004, 11'h008};
	localparam logic [10:0] CSC_WAIT_BASE      = 11'h003;
	localparam logic [10:0] CSC_GAP_CYC        = 11'h001;
	localparam int          CSC_SAMPLE_SHIFT   = 2;

	typedef enum logic [6:0] {
		CSC_IDLE    = 7'h01,
		CSC_DELAY   = 7'h02,
		CSC_SAMPLE  = 7'h04,
		CSC_GAP     = 7'h08,
		CSC_WAIT    = 7'h10,
		CSC_CONVERT = 7'h20,
		CSC_STORE   = 7'h40
	} csc_state_type;

	typedef struct packed {
		logic [4:0] channel;
		logic       filter_on;
		logic [1:0] vref_select;
		logic       comparator_bias_high;
		logic       opamp_bias_high;
		logic [1:0] offset_cancel_mode;
		logic       sample;
		logic       convert;
	} csc_analog_type;

endpackage : csc_pkg

// [rtl/csc_rate_gen.sv]
// fractional rate generator: makes a clock level and a rising-edge enable pulse
`timescale 1ns/10ps
module csc_rate_gen
	import csc_pkg::*;
(
	input  wire logic       clk_sys_in,
	input  wire logic       resetn_in,
	input  wire logic [4:0] rate_in,
	output logic            clk_out,
	output logic            rise_out
);
	logic [7:0] acc;
	logic [8:0] sum;

	assign sum = {1'b0, acc} + {4'h0, rate_in};

	// average toggle rate is rate_in MHz out of the system rate
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			acc      <= 8'h00;
			clk_out  <= 1'b0;
			rise_out <= 1'b0;
		end
		else if (sum >= CSC_SYS_MHZ)
		begin
			acc      <= 8'(sum - CSC_SYS_MHZ);
			clk_out  <= ~clk_out;
			rise_out <= ~clk_out;
		end
		else
		begin
			acc      <= sum[7:0];
			rise_out <= 1'b0;
		end
	end
endmodule : csc_rate_gen

// [rtl/csc_cycle_timer.sv]
// down counter of converter-clock cycles for the scan sequence
`timescale 1ns/10ps
module csc_cycle_timer
(
	input  wire logic        clk_sys_in,
	input  wire logic        resetn_in,
	input  wire logic        load_in,
	input  wire logic [10:0] value_in,
	input  wire logic        tick_in,
	output logic             done_out
);
	logic [10:0] count;

	assign done_out = (count == 11'h000);

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			count <= 11'h000;
		else if (load_in)
			count <= value_in;
		else if (tick_in && !done_out)
			count <= count - 11'h001;
	end
endmodule : csc_cycle_timer

// [tb/csc_scan_checker.sv]
// port assertions for the converter scan control block
`timescale 1ns/10ps
module csc_scan_checker
	import csc_pkg::*;
(
	input wire logic           clk_sys_in,
	input wire logic           resetn_in,
	input wire logic           psel_in,
	input wire logic           penable_in,
	input wire logic           pwrite_in,
	input wire logic [11:0]    paddr_in,
	input wire logic [31:0]    pwdata_in,
	input wire logic [31:0]    prdata_out,
	input wire logic           pready_out,
	input wire logic           pslverr_out,
	input wire logic           conv_done_in,
	input wire logic [11:0]    conv_result_in,
	input wire csc_analog_type analog_out,
	input wire logic           converter_clk_out,
	input wire logic           offset_clk_out,
	input wire logic           irq_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!resetn_in);

	logic        t2_wr;
	logic        hi_rd;
	logic [9:0]  samp_cnt;
	logic [11:0] gap_cnt;
	assign t2_wr = psel_in && penable_in && pwrite_in && paddr_in == {CSC_IDX_TIMING_TWO, 2'b00};
	assign hi_rd = psel_in && penable_in && !pwrite_in && paddr_in == {CSC_IDX_RES_HIGH, 2'b00};

	// cycles spent sampling, and cycles from the end of sampling to convert
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			samp_cnt <= 10'h000;
			gap_cnt  <= 12'h000;
		end
		else
		begin
			samp_cnt <= analog_out.sample ? samp_cnt + 10'h001 : 10'h000;
			if (analog_out.sample)
				gap_cnt <= 12'h000;
			else if (gap_cnt != 12'hfff)
				gap_cnt <= gap_cnt + 12'h001;
		end
	end

	mode_reset_a: assert property ($rose(resetn_in) |-> analog_out.offset_cancel_mode == 2'b10)
		else $error("offset mode not at reset value");
	result_high_a: assert property (hi_rd |-> prdata_out[31:4] == 28'h0)
		else $error("result high has bits above 3");
	sample_len_a: assert property ($fell(analog_out.sample) |-> samp_cnt >= 10'h05a && samp_cnt <= 10'h168)
		else $error("sample window length wrong");
	post_wait_a: assert property ($rose(analog_out.convert) |-> gap_cnt >= 12'h03c && gap_cnt <= 12'hc00)
		else $error("wait between sampling and convert wrong");
	conv_clk_a: assert property ($rose(converter_clk_out) |=> converter_clk_out [*8] ##[1:60] !converter_clk_out)
		else $error("converter clock high time wrong");
	offs_clk_a: assert property ($rose(offset_clk_out) |=> offset_clk_out [*8] ##[1:70] !offset_clk_out)
		else $error("offset clock high time wrong");
	front_end_a: assert property (t2_wr |=> analog_out.filter_on == $past(pwdata_in[6])
		&& {analog_out.opamp_bias_high, analog_out.comparator_bias_high} == $past(pwdata_in[3:2])
		&& analog_out.offset_cancel_mode == $past(pwdata_in[1:0]))
		else $error("front end fields differ from write");
	chan_hold_a: assert property (analog_out.sample |=> $stable(analog_out.channel))
		else $error("channel changed during scan");

	cover property ($rose(irq_out));
	cover property ($rose(analog_out.convert));
	cover property (pslverr_out);
endmodule : csc_scan_checker

bind csc_scan_control csc_scan_checker u_chk (.*);

// [tb/csc_conv_model.sv]
// behavioural analog converter core answering the convert request
`timescale 1ns/10ps
module csc_conv_model
(
	input  wire logic        clk_sys_in,
	input  wire logic        resetn_in,
	input  wire logic        convert_in,
	input  wire logic [7:0]  latency_in,
	input  wire logic [11:0] value_in,
	output logic             conv_done_out,
	output logic      [11:0] conv_result_out
);
	logic [7:0]  wait_cnt;
	logic [11:0] held;

	// result only valid while done is high; otherwise the inverse shows
	assign conv_result_out = conv_done_out ? held : ~held;

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			wait_cnt <= 8'h00;
			conv_done_out <= 1'b0;
			held <= 12'h000;
		end
		else if (!convert_in)
		begin
			wait_cnt <= 8'h00;
			conv_done_out <= 1'b0;
		end
		else if (wait_cnt == latency_in)
		begin
			held <= value_in;
			conv_done_out <= 1'b1;
		end
		else
			wait_cnt <= wait_cnt + 8'h01;
	end
endmodule : csc_conv_model

// [tb/csc_scan_control_tb.sv]
// register and scan sequence tests for the converter scan control block
`timescale 1ns/10ps
module csc_scan_control_tb;
	import csc_pkg::*;
	logic clk_sys_in = 0, resetn_in = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0, value = 0;
	logic [31:0] pwdata = 0, q;
	logic [7:0] latency = 5;
	logic er;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, done, conv_clk, offs_clk, irq;
	wire logic [11:0] res;
	csc_analog_type analog;
	int num_errors = 0, checks_done = 0, ticks = 0, i, c, t0, t1, t2;
	logic [9:0] idx [8] = '{CSC_IDX_SCAN, CSC_IDX_CLOCK, CSC_IDX_RES_HIGH, CSC_IDX_RES_LOW,
		CSC_IDX_TIMING_ONE, CSC_IDX_TIMING_TWO, CSC_IDX_IRQ_STATUS, CSC_IDX_IRQ_MASK};
	logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
	int cexp [4] = '{250, 333, 500, 667};
	int oexp [4] = '{167, 250, 500, 1000};
	logic [7:0] cfg [4] = '{8'h00, 8'h2d, 8'hfa, 8'h17};
	int dexp [4] = '{0, 2, 4, 8};
	int wexp [4] = '{3, 9, 34, 6};
	logic [11:0] vals [4] = '{12'hfff, 12'h5a3, 12'h001, 12'h800};
	logic [7:0] lat [4] = '{8'h05, 8'h28, 8'h03, 8'h5a};

	csc_scan_control u_dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .conv_done_in(done),
		.conv_result_in(res), .analog_out(analog), .converter_clk_out(conv_clk),
		.offset_clk_out(offs_clk), .irq_out(irq));
	csc_conv_model u_model (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .convert_in(analog.convert),
		.latency_in(latency), .value_in(value), .conv_done_out(done), .conv_result_out(res));

	always #2 clk_sys_in = ~clk_sys_in;
	always @(posedge conv_clk) ticks++;

	task print_verdict;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task near(input int a, input int b, input int tol);
		check(32'((a - b <= tol) && (b - a <= tol)), 32'h1);
	endtask : near

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys_in);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_sys_in);
			n++;
		end
		while (pready !== 1'b1 && n < 64);
		q = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys_in);
		if (n >= 64)
		begin
			num_errors++;
			print_verdict();
		end
	endtask : apb

	task wr(input logic [9:0] x, input logic [7:0] d);
		apb(1'b1, {x, 2'b00}, {24'h0, d});
	endtask : wr

	task rd(input logic [9:0] x, input logic [7:0] e);
		apb(1'b0, {x, 2'b00}, 32'h0);
		check(q, {24'h0, e});
	endtask : rd

	// bounded wait for a level; the hang case ends the run
	task wt(input int s, input logic lvl);
		int n;
		n = 0;
		while ((s == 0 ? analog.sample : analog.convert) !== lvl && n < 20000)
		begin
			@(posedge clk_sys_in);
			n++;
		end
		if (n >= 20000)
		begin
			num_errors++;
			print_verdict();
		end
	endtask : wt

	// cycles spanned by eight periods of the chosen clock
	task span(input logic off, output int cyc);
		int r;
		int n;
		logic p;
		r = 0;
		n = 0;
		cyc = 0;
		p = 1'b1;
		while (r < 9 && n < 5000)
		begin
			@(posedge clk_sys_in);
			n++;
			if ((off ? offs_clk : conv_clk) && !p)
				r++;
			if (r > 0)
				cyc++;
			p = off ? offs_clk : conv_clk;
		end
		if (n >= 5000)
		begin
			num_errors++;
			print_verdict();
		end
	endtask : span

	initial
	begin
		repeat (8) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		@(posedge clk_sys_in);
		for (i = 0; i < 8; i++)
			rd(idx[i], rv[i]);
		apb(1'b0, 12'h2dc, 32'h0);
		check({31'h0, er}, 32'h1);
		check(q, 32'h0);
		wr(CSC_IDX_RES_HIGH, 8'hff);
		rd(CSC_IDX_RES_HIGH, 8'h00);
		for (i = 3; i >= 0; i--)
		begin
			wr(CSC_IDX_CLOCK, 8'(i * 5));
			span(1'b0, c);
			span(1'b0, c);
			near(c, cexp[i], 4);
			span(1'b1, c);
			span(1'b1, c);
			near(c, oexp[i], 4);
		end
		// reference select kept at 01; its millivolt value comes from code flash, not this block
		for (i = 0; i < 2; i++)
		begin
			wr(CSC_IDX_TIMING_TWO, i ? 8'h1a : 8'h5d);
			check({analog.filter_on, analog.vref_select, analog.opamp_bias_high,
				analog.comparator_bias_high, analog.offset_cancel_mode}, i ? 7'h1a : 7'h5d);
			rd(CSC_IDX_TIMING_TWO, i ? 8'h1a : 8'h5d);
		end
		for (i = 0; i < 4; i++)
		begin
			wr(CSC_IDX_IRQ_MASK, 8'(i != 3));
			wr(CSC_IDX_TIMING_ONE, cfg[i]);
			value <= vals[i];
			latency <= lat[i];
			t0 = ticks;
			wr(CSC_IDX_SCAN, 8'h35);
			wt(0, 1'b1);
			t1 = ticks;
			near(t1 - t0, dexp[i], 1);
			rd(CSC_IDX_SCAN, 8'h35);
			check(analog.channel, 5'h1a);
			wt(0, 1'b0);
			t2 = ticks;
			near(t2 - t1, 4, 1);
			wt(1, 1'b1);
			near(ticks - t2, wexp[i], 1);
			wt(1, 1'b0);
			repeat (4) @(posedge clk_sys_in);
			check(irq, 32'(i != 3));
			rd(CSC_IDX_SCAN, 8'h34);
			rd(CSC_IDX_RES_HIGH, {4'h0, vals[i][11:8]});
			rd(CSC_IDX_RES_LOW, vals[i][7:0]);
			rd(CSC_IDX_IRQ_STATUS, 8'h01);
			rd(CSC_IDX_IRQ_STATUS, 8'h00);
			repeat (2) @(posedge clk_sys_in);
			check(irq, 32'h0);
			check(analog.sample, 32'h0);
		end
		print_verdict();
	end
endmodule : csc_scan_control_tb
